// [common/bps_pkg.sv]
// Constants, field layouts and carrier types for the pack status and setup registers.
package bps_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ          = 40000;
  localparam int unsigned TICK_MS          = 1;
  localparam int unsigned TICK_CYCLES      = TICK_MS * CLK_KHZ;
  localparam int unsigned LINE_RESET_US    = 120;
  localparam int unsigned LINE_RESET_CYCLES = (LINE_RESET_US * CLK_KHZ) / 1000;
  localparam int unsigned LOCKOUT_BASE_MS  = 512;
  localparam int unsigned HIGH_V_BASE_MS   = 512;
  localparam int unsigned LOW_V_BASE_MS    = 32;
  localparam int unsigned CURRENT_BASE_MS  = 2;
  localparam int unsigned DLY_W            = 13;

  // ---------------------------------------------------------------
  // Pages and byte offsets
  // ---------------------------------------------------------------
  localparam logic [1:0] PAGE_SETUP  = 2'h0;
  localparam logic [1:0] PAGE_STATUS = 2'h1;
  localparam logic [1:0] PAGE_ACCUM  = 2'h2;
  localparam logic [4:0] OFS_DELAY   = 5'h01;
  localparam logic [4:0] OFS_WARN    = 5'h02;
  localparam logic [4:0] OFS_ID_LO   = 5'h03;
  localparam logic [4:0] OFS_ID_HI   = 5'h04;
  localparam logic [4:0] OFS_STATUS  = 5'h00;
  localparam logic [4:0] OFS_SETUP   = 5'h01;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned DLY_LOCKOUT_LSB = 6;
  localparam int unsigned DLY_HIGHV_LSB   = 4;
  localparam int unsigned DLY_LOWV_LSB    = 2;
  localparam int unsigned DLY_CURR_LSB    = 0;
  localparam int unsigned ST_ONE_BIT      = 7;
  localparam int unsigned ST_PIN_BIT      = 6;
  localparam int unsigned ST_LOCK_BIT     = 5;
  localparam int unsigned CFG_COUNT_BIT   = 7;
  localparam int unsigned CFG_LIM_HI_BIT  = 6;
  localparam int unsigned CFG_LIM_LO_BIT  = 5;
  localparam int unsigned CFG_POR_BIT     = 4;
  localparam int unsigned CFG_DIR_BIT     = 1;
  localparam int unsigned CFG_MEAN_BIT    = 0;
  localparam logic [7:0]  DELAY_RESET     = 8'h00;
  localparam logic [7:0]  WARN_RESET      = 8'h00;
  localparam logic [7:0]  CFG_FIXED_ONES  = 8'h0C;
  localparam logic [7:0]  CFG_RW_MASK     = 8'hF3;
  localparam logic [7:0]  CFG_RESET       = 8'h83;
  localparam logic [7:0]  RESERVED_READ   = 8'h00;

  // ---------------------------------------------------------------
  // Function codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FN_LOCK   = 8'h43;
  localparam logic [7:0] FN_UNLOCK = 8'h44;

  // Delay channel index: high volt, low volt, discharge and charge current
  localparam int unsigned CH_HIGHV = 0;
  localparam int unsigned CH_LOWV  = 1;
  localparam int unsigned CH_DIS   = 2;
  localparam int unsigned CH_CHG   = 3;
  localparam int unsigned NUM_CH   = 4;

  // Register access request from the link protocol engine
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] page;
    logic [4:0] addr;
    logic [7:0] wdata;
  } bps_access_s;

  // Protection outcome toward the pack switches
  typedef struct packed {
    logic charge_en;
    logic discharge_en;
    logic low_power;
  } bps_switch_s;

endpackage

// [hdl/bps_regs.sv]
// Protection timing, status, setup and identity registers with line-level bus duties.
`timescale 1ns/1ps

module bps_regs
  import bps_pkg::*;
#(
  parameter int unsigned   SENSE_W          = 10,
  parameter int unsigned   MS_TICK_CYCLES   = TICK_CYCLES,
  parameter int unsigned   LINE_LOW_CYCLES  = LINE_RESET_CYCLES,
  parameter logic [15:0]   FACTORY_ID       = 16'hA5C3  // Arbitrary value
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // Link line, open drain
  input  wire logic               dq_in,
  output logic                    dq_out,
  output logic                    dq_oe,
  input  wire logic               link_drive_low,
  output logic                    link_reset_pulse,
  // Decoded register access and function codes from the protocol engine
  input  bps_access_s             access,
  input  wire logic               func_valid,
  input  wire logic [7:0]         func_code,
  output logic [7:0]              read_data,
  output logic                    read_valid,
  // General pin, open drain
  input  wire logic               pin_in,
  output logic                    pin_out,
  output logic                    pin_oe,
  input  wire logic               chan_write_valid,
  input  wire logic               chan_write_bit,
  // Analog comparator results and measurements
  input  wire logic               heat_over,
  input  wire logic [1:0]         cell_over_volt,
  input  wire logic [1:0]         cell_under_volt,
  input  wire logic [1:0]         cell_below_warn,
  input  wire logic signed [SENSE_W-1:0] sense_voltage,
  input  wire logic signed [SENSE_W-1:0] current_trip_level,
  input  wire logic [7:0]         remaining_charge_count,
  // Setup outputs toward measurement blocks
  output logic                    charge_counting_on,
  output logic [1:0]              counting_limit_sel,
  output logic                    sample_mean_sel,
  output logic                    general_pin_dir,
  // Pack switches
  output bps_switch_s             switches
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (MS_TICK_CYCLES < 2 || MS_TICK_CYCLES > 65535) begin : g_bad_tick
    $error("MS_TICK_CYCLES out of range");
  end
  if (LINE_LOW_CYCLES < 2 || LINE_LOW_CYCLES > 8191) begin : g_bad_line
    $error("LINE_LOW_CYCLES out of range");
  end
  if (SENSE_W < 2 || SENSE_W > 16) begin : g_bad_sense
    $error("SENSE_W out of range");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                     delay_sel;
    logic [7:0]                     warn_thr;
    logic [7:0]                     setup;
    logic                           locked;
    logic                           pin_mirror;
    logic                           pin_low;
    logic                           heat;
    logic                           warn;
    logic [NUM_CH-1:0]              trip;
    logic [NUM_CH-1:0][DLY_W-1:0]   cnt;
    logic                           oc_lock;
    logic [DLY_W-1:0]               lock_cnt;
    logic [15:0]                    pre;
    logic                           tick;
    logic [12:0]                    low_cnt;
    logic                           line_reset;
    logic                           drive;
    logic [7:0]                     rdata;
    logic                           rvalid;
    bps_switch_s                    sw;
  } bps_state_s;

  bps_state_s st;
  bps_state_s next_st;

  // Delay in ms for a two-bit code: base doubled per code step
  function automatic logic [DLY_W-1:0] delay_ms(input int unsigned base, input logic [1:0] code);
    logic [DLY_W-1:0] b;
    b = DLY_W'(base);
    return b << code;
  endfunction

  // Read-back value of one byte of the map
  function automatic logic [7:0] read_byte(input bps_state_s s, input logic [1:0] page,
                                           input logic [4:0] addr, input logic pin);
    logic [7:0] v;
    v = RESERVED_READ;
    if (page == PAGE_SETUP && addr == OFS_DELAY) begin
      v = s.delay_sel;
    end else if (page == PAGE_SETUP && addr == OFS_WARN) begin
      v = s.warn_thr;
    end else if (page == PAGE_SETUP && addr == OFS_ID_LO) begin
      v = FACTORY_ID[7:0];
    end else if (page == PAGE_SETUP && addr == OFS_ID_HI) begin
      v = FACTORY_ID[15:8];
    end else if (page == PAGE_STATUS && addr == OFS_STATUS) begin
      v = {1'b1, pin, s.locked, s.heat, s.trip[CH_HIGHV], s.trip[CH_LOWV], s.oc_lock, s.warn};
    end else if (page == PAGE_ACCUM && addr == OFS_SETUP) begin
      v = (s.setup & CFG_RW_MASK) | CFG_FIXED_ONES;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [NUM_CH-1:0]            cond;
    logic [NUM_CH-1:0][DLY_W-1:0] limit;
    logic                         take;
    logic                         pin_now;
    next_st = st;
    cond    = '0;
    limit   = '0;
    take    = 1'b0;
    pin_now = st.pin_mirror;

    // Slow tick prescaler; limited resolution of one tick is accepted on every delay
    next_st.tick = 1'b0;
    if (st.pre == 16'(MS_TICK_CYCLES - 1)) begin
      next_st.pre  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.pre = st.pre + 16'h0001;
    end

    // Line low timer; released line or a long low ends it
    next_st.line_reset = 1'b0;
    if (dq_in) begin
      next_st.low_cnt = '0;
    end else if (st.low_cnt != 13'(LINE_LOW_CYCLES)) begin
      next_st.low_cnt = st.low_cnt + 13'h0001;
      if (st.low_cnt == 13'(LINE_LOW_CYCLES - 1)) begin
        next_st.line_reset = 1'b1;
      end
    end
    // Pull low only; a long low drops our own drive so the slot is abandoned
    next_st.drive = link_drive_low && !next_st.line_reset && st.low_cnt != 13'(LINE_LOW_CYCLES);

    // Protection conditions and their selected delays
    cond[CH_HIGHV]  = |cell_over_volt;
    cond[CH_LOWV]   = |cell_under_volt;
    cond[CH_DIS]    = sense_voltage > current_trip_level;
    cond[CH_CHG]    = sense_voltage < -current_trip_level;
    limit[CH_HIGHV] = delay_ms(HIGH_V_BASE_MS, st.delay_sel[DLY_HIGHV_LSB +: 2]);
    limit[CH_LOWV]  = delay_ms(LOW_V_BASE_MS, st.delay_sel[DLY_LOWV_LSB +: 2]);
    limit[CH_DIS]   = delay_ms(CURRENT_BASE_MS, st.delay_sel[DLY_CURR_LSB +: 2]);
    limit[CH_CHG]   = limit[CH_DIS];

    // Continuous-condition counters; a gap clears the count
    for (int i = 0; i < NUM_CH; i++) begin
      if (!cond[i] || (st.oc_lock && i >= CH_DIS)) begin
        next_st.cnt[i]  = '0;
        next_st.trip[i] = 1'b0;
      end else if (st.tick && !st.trip[i]) begin
        next_st.cnt[i] = st.cnt[i] + 13'h0001;
        if (st.cnt[i] + 13'h0001 >= limit[i]) begin
          next_st.trip[i] = 1'b1;
        end
      end
    end

    // Overcurrent lockout holds both switches off for the selected time
    if (next_st.trip[CH_DIS] || next_st.trip[CH_CHG]) begin
      next_st.oc_lock  = 1'b1;
      next_st.lock_cnt = '0;
    end else if (st.oc_lock && st.tick) begin
      next_st.lock_cnt = st.lock_cnt + 13'h0001;
      if (st.lock_cnt + 13'h0001 >= delay_ms(LOCKOUT_BASE_MS, st.delay_sel[DLY_LOCKOUT_LSB +: 2])) begin
        next_st.oc_lock = 1'b0;
      end
    end

    // Status flags
    next_st.heat = heat_over;
    if (remaining_charge_count < st.warn_thr || |cell_below_warn) begin
      next_st.warn = 1'b1;
    end else if (remaining_charge_count > st.warn_thr) begin
      next_st.warn = 1'b0;
    end

    // Switch outputs
    next_st.sw.charge_en    = !(next_st.trip[CH_HIGHV] || next_st.trip[CH_LOWV] || next_st.oc_lock
                                || heat_over);
    next_st.sw.discharge_en = !(next_st.trip[CH_LOWV] || next_st.oc_lock || heat_over);
    next_st.sw.low_power    = next_st.trip[CH_LOWV];

    // Lock and unlock function codes
    if (func_valid && !next_st.line_reset) begin
      if (func_code == FN_LOCK) begin
        next_st.locked = 1'b1;
      end else if (func_code == FN_UNLOCK) begin
        next_st.locked = 1'b0;
      end
    end

    // Pin channel writes only when the direction bit says write
    if (chan_write_valid && !st.setup[CFG_DIR_BIT]) begin
      next_st.pin_low = !chan_write_bit;
    end

    // Register access; a reset pulse in the same cycle abandons it
    take           = access.valid && !next_st.line_reset;
    next_st.rvalid = 1'b0;
    if (take && access.page == PAGE_STATUS) begin
      next_st.pin_mirror = pin_in;
      pin_now            = pin_in;
    end
    if (take && !access.write) begin
      next_st.rdata  = read_byte(st, access.page, access.addr, pin_now);
      next_st.rvalid = 1'b1;
    end
    if (take && access.write) begin
      if (access.page == PAGE_SETUP && !st.locked && access.addr == OFS_DELAY) begin
        next_st.delay_sel = access.wdata;
      end
      if (access.page == PAGE_SETUP && !st.locked && access.addr == OFS_WARN) begin
        next_st.warn_thr = access.wdata;
      end
      if (access.page == PAGE_ACCUM && access.addr == OFS_SETUP) begin
        next_st.setup = (access.wdata & CFG_RW_MASK & ~(8'h01 << CFG_POR_BIT))
                        | (st.setup & (8'h01 << CFG_POR_BIT));
        if (access.wdata[CFG_POR_BIT]) begin
          next_st.setup[CFG_POR_BIT] = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st            <= '0;
      st.delay_sel  <= DELAY_RESET;
      st.warn_thr   <= WARN_RESET;
      st.setup      <= CFG_RESET;
      st.locked     <= 1'b1;
      st.pin_mirror <= 1'b1;
      st.sw         <= '{charge_en: 1'b1, discharge_en: 1'b1, low_power: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, straight from state flops except dq_out and pin_out, which are tied low
  // ---------------------------------------------------------------
  assign dq_out             = 1'b0;
  assign dq_oe              = st.drive;
  assign link_reset_pulse   = st.line_reset;
  assign read_data          = st.rdata;
  assign read_valid         = st.rvalid;
  assign pin_out            = 1'b0;
  assign pin_oe             = st.pin_low;
  assign charge_counting_on = st.setup[CFG_COUNT_BIT];
  assign counting_limit_sel = {st.setup[CFG_LIM_HI_BIT], st.setup[CFG_LIM_LO_BIT]};
  assign sample_mean_sel    = st.setup[CFG_MEAN_BIT];
  assign general_pin_dir    = st.setup[CFG_DIR_BIT];
  assign switches           = st.sw;

endmodule

// [sim/bps_host_model.sv]
// Host bus master model on the shared pulled-up line.
`timescale 1ns/1ps

module bps_host_model (
  // Clock
  input wire logic clk_sys,
  // Line
  input wire logic dev_oe,
  output logic     dq_level
);
  logic host_low = 1'b0;

  // Wire-AND with pull-up: any party pulling low wins
  assign dq_level = !(host_low || dev_oe);

  // Pull low for n cycles, then leave the line idle high
  task automatic pull_low(input int n);
    @(posedge clk_sys);
    host_low <= 1'b1;
    repeat (n) @(posedge clk_sys);
    host_low <= 1'b0;
  endtask
endmodule

// [sim/bps_regs_assertions.sv]
// Port-level assertions for the pack register block.
`timescale 1ns/1ps

module bps_regs_chk
  import bps_pkg::*;
#(
  parameter int unsigned LINE_LOW_CYCLES = LINE_RESET_CYCLES
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // Line and general pin
  input wire logic       dq_in,
  input wire logic       dq_out,
  input wire logic       dq_oe,
  input wire logic       link_drive_low,
  input wire logic       link_reset_pulse,
  input wire logic       pin_in,
  input wire logic       pin_out,
  input wire logic       pin_oe,
  input wire logic       chan_write_valid,
  input wire logic       general_pin_dir,
  // Register path and protection
  input bps_access_s     access,
  input wire logic       func_valid,
  input wire logic [7:0] func_code,
  input wire logic [7:0] read_data,
  input wire logic       read_valid,
  input wire logic       heat_over,
  input bps_switch_s     switches
);
  logic [15:0] low_cnt;
  logic        pulse_seen;

  // Low-run counter; saturates so a stuck line never wraps
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt    <= 16'h0000;
      pulse_seen <= 1'b0;
    end else if (dq_in) begin
      low_cnt    <= 16'h0000;
      pulse_seen <= 1'b0;
    end else begin
      low_cnt    <= (low_cnt == 16'hFFFF) ? low_cnt : low_cnt + 16'h0001;
      pulse_seen <= pulse_seen | link_reset_pulse;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence lock_cmd;
    func_valid && func_code == FN_LOCK;
  endsequence
  sequence unlock_cmd;
    func_valid && func_code == FN_UNLOCK;
  endsequence
  // Status read with no competing strobe and the line idle
  sequence stat_rd;
    access.valid && !access.write && access.page == PAGE_STATUS && access.addr == OFS_STATUS && !func_valid && dq_in;
  endsequence
  sequence cfg_rd;
    access.valid && !access.write && access.page == PAGE_ACCUM && access.addr == OFS_SETUP;
  endsequence

  open_drain_a: assert property (!dq_out && !pin_out) else $error("pin driven high");
  drive_request_a: assert property (!link_drive_low |=> !dq_oe) else $error("line pulled unasked");
  read_answer_a: assert property (access.valid && !access.write && dq_in |=> read_valid) else $error("no read answer");
  read_cause_a: assert property (read_valid |-> $past(access.valid && !access.write)) else $error("stray read answer");
  status_one_a: assert property (stat_rd |=> read_data[ST_ONE_BIT]) else $error("status top bit low");
  pin_mirror_a: assert property (stat_rd |=> read_data[ST_PIN_BIT] == $past(pin_in)) else $error("pin mirror wrong");
  lock_flag_a: assert property (lock_cmd ##1 stat_rd |=> read_data[ST_LOCK_BIT]) else $error("lock flag clear");
  unlock_flag_a: assert property (unlock_cmd ##1 stat_rd |=> !read_data[ST_LOCK_BIT]) else $error("lock flag set");
  cfg_ones_a: assert property (cfg_rd |=> read_data[3:2] == 2'b11) else $error("setup fixed bits low");
  line_early_a: assert property (link_reset_pulse |-> low_cnt >= LINE_LOW_CYCLES - 1) else $error("reset pulse early");
  line_late_a: assert property (low_cnt == LINE_LOW_CYCLES + 2 |-> pulse_seen) else $error("reset pulse missing");
  heat_off_a: assert property (heat_over [*3] |-> !switches.charge_en && !switches.discharge_en) else $error("heat ignored");
  low_power_a: assert property (switches.low_power |-> !switches.charge_en && !switches.discharge_en) else $error("low power on");
  chan_locked_a: assert property (chan_write_valid && general_pin_dir |=> $stable(pin_oe)) else $error("pin written");
endmodule

bind bps_regs bps_regs_chk #(.LINE_LOW_CYCLES(LINE_LOW_CYCLES)) bps_regs_chk_i (.clk_sys, .rst_b, .dq_in, .dq_out,
  .dq_oe, .link_drive_low, .link_reset_pulse, .pin_in, .pin_out, .pin_oe, .chan_write_valid, .general_pin_dir,
  .access, .func_valid, .func_code, .read_data, .read_valid, .heat_over, .switches);

// [sim/bps_regs_test.sv]
// Self-checking bench for the pack register block.
`timescale 1ns/1ps

module bps_regs_test;
  import bps_pkg::*;
  localparam logic [15:0] ID = 16'h3C96; // Arbitrary value
  logic              clk_sys, rst_b, link_drive_low, func_valid, chan_write_valid, chan_write_bit, heat_over;
  logic              dq_in, dq_oe, link_reset_pulse, read_valid, pin_in, pin_oe, ext_low, lock, por, warn;
  logic              charge_counting_on, sample_mean_sel, general_pin_dir;
  logic [7:0]        func_code, read_data, remaining_charge_count, rd, w, thr;
  logic [1:0]        cell_over_volt, cell_under_volt, cell_below_warn, counting_limit_sel;
  logic signed [9:0] sense_voltage, current_trip_level;
  logic [31:0]       seed;
  bps_access_s       access;
  bps_switch_s       switches;
  int                err_count, samples_checked, cyc, pulses;

  assign pin_in = !(pin_oe || ext_low);

  bps_regs #(.SENSE_W(10), .MS_TICK_CYCLES(4), .LINE_LOW_CYCLES(20), .FACTORY_ID(ID)) bps_regs_i (.clk_sys, .rst_b,
    .dq_in, .dq_out(), .dq_oe, .link_drive_low, .link_reset_pulse, .access, .func_valid, .func_code, .read_data,
    .read_valid, .pin_in, .pin_out(), .pin_oe, .chan_write_valid, .chan_write_bit, .heat_over, .cell_over_volt,
    .cell_under_volt, .cell_below_warn, .sense_voltage, .current_trip_level, .remaining_charge_count,
    .charge_counting_on, .counting_limit_sel, .sample_mean_sel, .general_pin_dir, .switches);
  bps_host_model bps_host_model_i (.clk_sys, .dev_oe(dq_oe), .dq_level(dq_in));

  // ---------------------------------------------------------------
  // Clock, watchdog and helpers
  // ---------------------------------------------------------------
  always #12.5 clk_sys = ~clk_sys;

  // Reset pulses counted here; watchdog ends a hung run
  always @(posedge clk_sys) begin
    cyc++;
    if (link_reset_pulse === 1'b1) pulses++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One register access; read byte lands in rd
  task automatic acc(input logic wr, input logic [1:0] pg, input logic [4:0] ad, input logic [7:0] wd);
    @(posedge clk_sys);
    func_valid <= 1'b0;
    access <= '{1'b1, wr, pg, ad, wd};
    @(posedge clk_sys);
    access.valid <= 1'b0;
    #1;
    rd = read_data;
    if (!wr) chk(read_valid, 1'b1);
  endtask

  // Strobe only raised; the following access drops it
  task automatic fn(input logic [7:0] c);
    @(posedge clk_sys);
    func_valid <= 1'b1;
    func_code <= c;
  endtask

  task automatic chan(input logic b);
    @(posedge clk_sys);
    chan_write_valid <= 1'b1;
    chan_write_bit <= b;
    @(posedge clk_sys);
    chan_write_valid <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected status byte, pin idle high
  function automatic logic [7:0] st(input logic [3:0] f);
    return {2'b11, lock, f, warn};
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 0;
    rst_b = 0;
    access = '0;
    {func_valid, func_code, link_drive_low, chan_write_valid, chan_write_bit, heat_over, ext_low} = '0;
    {cell_over_volt, cell_under_volt, cell_below_warn, sense_voltage} = '0;
    current_trip_level = 10'sd100;
    remaining_charge_count = 8'h40;
    seed = 80509;
    {lock, por, warn, thr} = {3'b100, 8'h00};
    tick(8);
    rst_b <= 1'b1;
    acc(0, PAGE_SETUP, OFS_DELAY, 0);
    chk(rd, 8'h00);
    acc(0, PAGE_ACCUM, OFS_SETUP, 0);
    chk(rd, 8'h8F);
    acc(0, PAGE_SETUP, 5'h10, 0);
    chk(rd, RESERVED_READ);
    // Locked page 0 refuses writes until unlocked
    acc(1, PAGE_SETUP, OFS_DELAY, 8'hB4);
    acc(0, PAGE_SETUP, OFS_DELAY, 0);
    chk(rd, 8'h00);
    fn(FN_UNLOCK);
    lock = 0;
    acc(0, PAGE_STATUS, OFS_STATUS, 0);
    chk(rd, st(0));
    acc(1, PAGE_SETUP, OFS_DELAY, 8'hB4);
    acc(0, PAGE_SETUP, OFS_DELAY, 0);
    chk(rd, 8'hB4);
    acc(1, PAGE_SETUP, OFS_ID_LO, 8'hFF);
    acc(0, PAGE_SETUP, OFS_ID_LO, 0);
    chk(rd, ID[7:0]);
    acc(0, PAGE_SETUP, OFS_ID_HI, 0);
    chk(rd, ID[15:8]);
    acc(1, PAGE_STATUS, OFS_STATUS, 8'h00);
    acc(0, PAGE_STATUS, OFS_STATUS, 0);
    chk(rd, st(0));
    // Random setup writes against the bench model
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      w = seed[7:0] | ((i == 3) ? 8'h10 : 8'h00);
      por = por | w[4];
      acc(1, PAGE_ACCUM, OFS_SETUP, w);
      acc(0, PAGE_ACCUM, OFS_SETUP, 0);
      chk(rd, (w & CFG_RW_MASK) | CFG_FIXED_ONES | {3'b000, por, 4'h0});
      chk({charge_counting_on, counting_limit_sel, general_pin_dir, sample_mean_sel}, {w[7:5], w[1:0]});
    end
    // Pin channel writes only with direction cleared
    acc(1, PAGE_ACCUM, OFS_SETUP, 8'h80);
    chan(0);
    acc(0, PAGE_STATUS, OFS_STATUS, 0);
    chk({pin_oe, rd[6]}, 2'b10);
    chan(1);
    acc(0, PAGE_STATUS, OFS_STATUS, 0);
    chk({pin_oe, rd[6]}, 2'b01);
    acc(1, PAGE_ACCUM, OFS_SETUP, 8'h83);
    chan(0);
    ext_low <= 1'b1;
    acc(0, PAGE_STATUS, OFS_STATUS, 0);
    chk({pin_oe, rd[6]}, 2'b00);
    ext_low <= 1'b0;
    // Capacity warning against threshold and cells
    thr = 8'h80;
    acc(1, PAGE_SETUP, OFS_WARN, thr);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      w = (i == 4) ? thr : seed[15:8];
      @(posedge clk_sys);
      remaining_charge_count <= w;
      cell_below_warn <= (i == 2) ? 2'b10 : 2'b00;
      if (w < thr || i == 2) warn = 1;
      else if (w > thr) warn = 0;
      tick(4);
      acc(0, PAGE_STATUS, OFS_STATUS, 0);
      chk(rd, st(0));
    end
    remaining_charge_count <= 8'hF0;
    warn = 0;
    acc(1, PAGE_SETUP, OFS_DELAY, 8'h04);
    // Heat, then low volt with a restart, then high volt
    heat_over <= 1'b1;
    acc(0, PAGE_STATUS, OFS_STATUS, 0);
    chk(rd, st(4'h8));
    tick(2);
    heat_over <= 1'b0;
    cell_under_volt <= 2'b01;
    tick(200);
    cell_under_volt <= 2'b00;
    tick(5);
    cell_under_volt <= 2'b10;
    tick(200);
    chk(switches, 3'b110);
    tick(100);
    chk(switches, 3'b001);
    acc(0, PAGE_STATUS, OFS_STATUS, 0);
    chk(rd, st(4'h2));
    cell_under_volt <= 2'b00;
    cell_over_volt <= 2'b01;
    tick(1990);
    chk(switches, 3'b110);
    tick(120);
    chk(switches, 3'b010);
    cell_over_volt <= 2'b00;
    // Discharge then charge overcurrent with lockout
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      sense_voltage <= s ? -10'sd200 : 10'sd200;
      tick(20);
      sense_voltage <= 10'sd0;
      acc(0, PAGE_STATUS, OFS_STATUS, 0);
      chk(rd, st(4'h1));
      tick(1880);
      chk(switches, 3'b000);
      tick(300);
      chk(switches, 3'b110);
    end
    // Lock again; page 0 then refuses the delay write
    fn(FN_LOCK);
    lock = 1;
    acc(0, PAGE_STATUS, OFS_STATUS, 0);
    chk(rd, st(0));
    acc(1, PAGE_SETUP, OFS_DELAY, 8'h55);
    acc(0, PAGE_SETUP, OFS_DELAY, 0);
    chk(rd, 8'h04);
    // Line lows, short and long, and device pull
    bps_host_model_i.pull_low(10);
    tick(4);
    chk(pulses, 0);
    bps_host_model_i.pull_low(25);
    tick(4);
    chk(pulses, 1);
    link_drive_low <= 1'b1;
    tick(3);
    chk({dq_oe, dq_in}, 2'b10);
    link_drive_low <= 1'b0;
    // Second reset restores defaults
    rst_b <= 1'b0;
    tick(2);
    rst_b <= 1'b1;
    lock = 1;
    acc(0, PAGE_ACCUM, OFS_SETUP, 0);
    chk(rd, 8'h8F);
    acc(0, PAGE_SETUP, OFS_DELAY, 0);
    chk(rd, 8'h00);
    acc(0, PAGE_STATUS, OFS_STATUS, 0);
    chk(rd, st(0));
    end_sim();
  end
endmodule
